//--- rtl/dce_chan.sv
`timescale 1ns/1ps
module dce_chan (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic en_wr,
    input  wire logic en_wval,
    input  wire logic edet_wr,
    input  wire logic edet_wval,
    input  wire logic end_event,
    input  wire logic auto_dis,
    input  wire logic irq_en,
    input  wire logic req_in,
    input  wire logic req_take,
    output logic      enable,
    output logic      end_detect,
    output logic      irq_status,
    output logic      pending
);
    import dce_pkg::*;

    logic en_r, en_nxt, edet_r, edet_nxt, irq_r, irq_nxt, pend_r, pend_nxt;

    always_comb begin
        en_nxt = en_r;
        if (en_wr) begin
            en_nxt = en_wval;
        end
        // The end condition clearing the enable overrides a software write in the same cycle.
        if (end_event && auto_dis) begin
            en_nxt = 1'b0;
        end
        edet_nxt = edet_r;
        if (edet_wr && !edet_wval) begin
            edet_nxt = 1'b0;
        end
        if (end_event) begin
            edet_nxt = 1'b1;
        end
        // Status survives only while both its end flag and its enable stand.
        irq_nxt = (irq_r && edet_nxt && irq_en) || (end_event && irq_en);
        pend_nxt = pend_r;
        if (req_take) begin
            pend_nxt = 1'b0;
        end
        if (req_in) begin
            pend_nxt = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_r   <= BIT_RST;
            edet_r <= BIT_RST;
            irq_r  <= BIT_RST;
            pend_r <= BIT_RST;
        end else begin
            en_r   <= en_nxt;
            edet_r <= edet_nxt;
            irq_r  <= irq_nxt;
            pend_r <= pend_nxt;
        end
    end

    assign enable     = en_r;
    assign end_detect = edet_r;
    assign irq_status = irq_r;
    assign pending    = pend_r;
endmodule // dce_chan

//--- rtl/dce_ctrl.sv
`timescale 1ns/1ps
module dce_ctrl (
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [11:0]     paddr,
    input  wire logic [31:0]     pwdata,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    dce_link_if.ctrl             link
);
    import dce_pkg::*;

    logic            pready_r, pready_nxt;
    logic [31:0]     prdata_r, prdata_nxt;
    logic [4:0]      ctrl_r, ctrl_nxt;
    logic [7:0]      ev_r, ev_nxt;
    logic [23:0]     addr_r, addr_nxt;
    logic [31:0]     wdat_r, wdat_nxt;
    logic [31:0]     rdat_r, rdat_nxt;
    logic [3:0]      be_r, be_nxt;
    logic            dir_r, dir_nxt;
    logic            req_r, req_nxt;
    logic            wr_acc;
    logic [31:0]     status;

    // Writes take effect only at the edge that completes the access phase.
    assign wr_acc = psel && penable && pwrite && pready_r;

    always_comb begin
        status                          = REG_RST;
        status[ST_EN_POS +: NCH]        = link.channel_transfer_enable;
        status[ST_PEND_POS +: NCH]      = link.request_pending;
        status[ST_GRANT_POS +: NCH]     = link.bus_grant;
        status[ST_RUN_POS]              = link.operand_running;
        status[ST_BUSY_POS]             = req_r;
        status[ST_IRQ_POS +: NCH]       = link.irq_request;
    end

    always_comb begin
        pready_nxt = psel && !penable;
        prdata_nxt = prdata_r;
        if (psel && !penable) begin
            case (paddr)
                CTL_CTRL_OFS:   prdata_nxt = {27'h0, ctrl_r};
                CTL_ADDR_OFS:   prdata_nxt = {8'h00, addr_r};
                CTL_WDATA_OFS:  prdata_nxt = wdat_r;
                CTL_CMD_OFS:    prdata_nxt = {27'h0, dir_r, be_r};
                CTL_RDATA_OFS:  prdata_nxt = rdat_r;
                CTL_STATUS_OFS: prdata_nxt = status;
                default:        prdata_nxt = REG_RST;
            endcase
        end
        ctrl_nxt = ctrl_r;
        ev_nxt   = '0;
        addr_nxt = addr_r;
        wdat_nxt = wdat_r;
        be_nxt   = be_r;
        dir_nxt  = dir_r;
        req_nxt  = req_r;
        rdat_nxt = rdat_r;
        if (wr_acc) begin
            case (paddr)
                CTL_CTRL_OFS:  ctrl_nxt = pwdata[4:0];
                CTL_EVENT_OFS: ev_nxt   = pwdata[7:0];
                CTL_ADDR_OFS:  addr_nxt = pwdata[23:0];
                CTL_WDATA_OFS: wdat_nxt = pwdata;
                CTL_CMD_OFS: begin
                    // A command while one is still outstanding is dropped.
                    if (!req_r) begin
                        be_nxt  = pwdata[CMD_BE_POS +: 4];
                        dir_nxt = pwdata[CMD_WRITE_POS];
                        req_nxt = 1'b1;
                    end
                end
                default: begin
                    ctrl_nxt = ctrl_r;
                end
            endcase
        end
        if (req_r && link.dev_ack) begin
            req_nxt = 1'b0;
            if (!dir_r) begin
                rdat_nxt = link.dev_rdata;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            prdata_r <= REG_RST;
            ctrl_r   <= '0;
            ev_r     <= '0;
            addr_r   <= '0;
            wdat_r   <= REG_RST;
            be_r     <= '0;
            dir_r    <= 1'b0;
            req_r    <= 1'b0;
            rdat_r   <= REG_RST;
        end else begin
            pready_r <= pready_nxt;
            prdata_r <= prdata_nxt;
            ctrl_r   <= ctrl_nxt;
            ev_r     <= ev_nxt;
            addr_r   <= addr_nxt;
            wdat_r   <= wdat_nxt;
            be_r     <= be_nxt;
            dir_r    <= dir_nxt;
            req_r    <= req_nxt;
            rdat_r   <= rdat_nxt;
        end
    end

    assign prdata                    = prdata_r;
    assign pready                    = pready_r;
    assign pslverr                   = 1'b0;
    assign link.dev_req              = req_r;
    assign link.dev_write            = dir_r;
    assign link.dev_addr             = addr_r;
    assign link.dev_be               = be_r;
    assign link.dev_wdata            = wdat_r;
    assign link.dma_request          = ev_r[EV_REQ_POS +: NCH];
    assign link.end_event            = ev_r[EV_END_POS +: NCH];
    assign link.operand_done         = ev_r[EV_DONE_POS +: NCH];
    assign link.transfer_state_abort = ev_r[EV_ABORT_POS +: NCH];
    assign link.end_irq_enable       = ctrl_r[CF_IRQEN_POS +: NCH];
    assign link.auto_disable_on_end  = ctrl_r[CF_AUTODIS_POS +: NCH];
    assign link.burst_mode           = ctrl_r[CF_BURST_POS];
endmodule // dce_ctrl

//--- rtl/dce_device.sv
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
// Summary of operation
// - Registers take byte, halfword and word access; enable writes lacking byte lane 2 or 3 are ignored.
// - Unassigned enable bits written zero, read zero.
// - Mask zero in write keeps enable unchanged.
// - Mask one in write loads enable value.
// - Mask bits hold nothing, always read zero.
// - Software sets mask with every enable change.
// - Transfers start only on enabled channels.
// - Request pending tracks requests while disabled.
// - End with auto-disable clears channel enable.
// - Cycle-steal: all enables off pauses, on resumes.
// - No channel switch during running/paused operand.
// - Abort bit ends paused operand, frees bus.
// - Software clears all enables to pause.
// - Interrupt status register ignores writes.
// - Status one means interrupt is requested.
// - End with interrupt enable sets flag, status.
// - Clearing end flag clears interrupt status.
// - Clearing interrupt enable clears interrupt status.
// - End flag set on finish, held till cleared.
// - Write zero clears end flag; one keeps.
module dce_device (
    input  wire logic     pclk,
    input  wire logic     presetn,
    dce_link_if.device    link
);
    import dce_pkg::*;

    logic [NCH-1:0]  en;
    logic [NCH-1:0]  edet;
    logic [NCH-1:0]  irq_sts;
    logic [NCH-1:0]  pend;
    logic [NCH-1:0]  en_wr;
    logic [NCH-1:0]  edet_wr;
    logic [NCH-1:0]  take;

    logic            acc;
    logic            acc_wr;
    logic            hit_en;
    logic            hit_irq;
    logic            hit_edet;
    logic            ack_r;
    logic            ack_nxt;
    logic [31:0]     rdata_r;
    logic [31:0]     rdata_nxt;

    dce_xfer_state_t st_r;
    dce_xfer_state_t st_nxt;
    logic            ch_r;
    logic            ch_nxt;
    logic [NCH-1:0]  grant_r;
    logic [NCH-1:0]  grant_nxt;
    logic            run_r;
    logic            run_nxt;
    logic            owner_done;
    logic            owner_abort;
    logic            all_off;

    // A request is taken once; the held request during the acknowledge cycle is not taken again.
    assign acc      = link.dev_req && !ack_r;
    assign acc_wr   = acc && link.dev_write;

    assign hit_en   = (link.dev_addr == DEV_ENABLE_OFS);
    assign hit_irq  = (link.dev_addr == DEV_IRQ_STS_OFS);
    assign hit_edet = (link.dev_addr == DEV_END_DET_OFS);

    assign owner_done  = link.operand_done[ch_r];
    assign owner_abort = link.transfer_state_abort[ch_r];
    // A pause needs every enable off; one left on is a software fault that is not guarded.
    assign all_off     = (en == '0);

    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_ch
            // Mask and enable live in different byte lanes; a write lacking the mask lane is masked.
            assign en_wr[gi]   = acc_wr && hit_en
                                 && link.dev_be[MASK_POS/8] && link.dev_be[EN_POS/8]
                                 && link.dev_wdata[MASK_POS+gi];
            assign edet_wr[gi] = acc_wr && hit_edet && link.dev_be[EDET_POS/8];

            dce_chan u_chan (
                .pclk       (pclk),
                .presetn    (presetn),
                .en_wr      (en_wr[gi]),
                .en_wval    (link.dev_wdata[EN_POS+gi]),
                .edet_wr    (edet_wr[gi]),
                .edet_wval  (link.dev_wdata[EDET_POS+gi]),
                .end_event  (link.end_event[gi]),
                .auto_dis   (link.auto_disable_on_end[gi]),
                .irq_en     (link.end_irq_enable[gi]),
                .req_in     (link.dma_request[gi]),
                .req_take   (take[gi]),
                .enable     (en[gi]),
                .end_detect (edet[gi]),
                .irq_status (irq_sts[gi]),
                .pending    (pend[gi])
            );
        end
    endgenerate

    // Register port: one acknowledge cycle after each taken request.
    always_comb begin
        ack_nxt   = acc;
        rdata_nxt = rdata_r;

        if (acc) begin
            // Write cycles answer with zero data so a stale read value never looks fresh.
            rdata_nxt = REG_RST;
            if (!link.dev_write) begin
                // Mask bits and unassigned bits are never stored, so they read zero.
                if (hit_en) begin
                    rdata_nxt[EN_POS +: NCH] = en;
                end else if (hit_irq) begin
                    rdata_nxt[IRQ_POS +: NCH] = irq_sts;
                end else if (hit_edet) begin
                    rdata_nxt[EDET_POS +: NCH] = edet;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_r   <= 1'b0;
            rdata_r <= REG_RST;
        end else begin
            ack_r   <= ack_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Single-operand transfer tracking and bus ownership.
    always_comb begin
        st_nxt    = st_r;
        ch_nxt    = ch_r;
        take      = '0;

        case (st_r)
            DCE_IDLE: begin
                // Fixed priority: channel 0 ahead of channel 1.
                if (en[0] && pend[0]) begin
                    st_nxt  = DCE_RUN;
                    ch_nxt  = 1'b0;
                    take[0] = 1'b1;
                end else if (en[1] && pend[1]) begin
                    st_nxt  = DCE_RUN;
                    ch_nxt  = 1'b1;
                    take[1] = 1'b1;
                end
            end

            DCE_RUN: begin
                // Burst mode never pauses; cleared enables there only block the next start.
                if (owner_done || owner_abort) begin
                    st_nxt = DCE_IDLE;
                end else if (!link.burst_mode && all_off) begin
                    st_nxt = DCE_HALT;
                end
            end

            DCE_HALT: begin
                // While halted the owner is kept; only abort or resume leaves this state.
                if (owner_abort) begin
                    st_nxt = DCE_IDLE;
                end else if (en[ch_r]) begin
                    st_nxt = DCE_RUN;
                end
            end

            default: begin
                st_nxt = DCE_IDLE;
            end
        endcase

        grant_nxt = '0;
        if (st_nxt != DCE_IDLE) begin
            grant_nxt[ch_nxt] = 1'b1;
        end

        run_nxt = (st_nxt == DCE_RUN);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r    <= DCE_IDLE;
            ch_r    <= 1'b0;
            grant_r <= '0;
            run_r   <= 1'b0;
        end else begin
            st_r    <= st_nxt;
            ch_r    <= ch_nxt;
            grant_r <= grant_nxt;
            run_r   <= run_nxt;
        end
    end

    assign link.dev_ack                 = ack_r;
    assign link.dev_rdata               = rdata_r;

    assign link.channel_transfer_enable = en;
    assign link.request_pending         = pend;
    assign link.bus_grant               = grant_r;
    assign link.operand_running         = run_r;

    assign link.irq_request             = irq_sts;
endmodule // dce_device

//--- shared/dce_link_if.sv
`timescale 1ns/1ps
interface dce_link_if;
    import dce_pkg::*;
    logic                 dev_req;
    logic                 dev_write;
    logic [DEV_AW-1:0]    dev_addr;
    logic [3:0]           dev_be;
    logic [31:0]          dev_wdata;
    logic [31:0]          dev_rdata;
    logic                 dev_ack;
    logic [NCH-1:0]       dma_request;
    logic [NCH-1:0]       end_event;
    logic [NCH-1:0]       operand_done;
    logic [NCH-1:0]       transfer_state_abort;
    logic [NCH-1:0]       end_irq_enable;
    logic [NCH-1:0]       auto_disable_on_end;
    logic                 burst_mode;
    logic [NCH-1:0]       channel_transfer_enable;
    logic [NCH-1:0]       request_pending;
    logic [NCH-1:0]       bus_grant;
    logic                 operand_running;
    logic [NCH-1:0]       irq_request;

    modport device (
        input  dev_req, dev_write, dev_addr, dev_be, dev_wdata,
        output dev_rdata, dev_ack,
        input  dma_request, end_event, operand_done, transfer_state_abort,
        input  end_irq_enable, auto_disable_on_end, burst_mode,
        output channel_transfer_enable, request_pending, bus_grant, operand_running, irq_request
    );
    modport ctrl (
        output dev_req, dev_write, dev_addr, dev_be, dev_wdata,
        input  dev_rdata, dev_ack,
        output dma_request, end_event, operand_done, transfer_state_abort,
        output end_irq_enable, auto_disable_on_end, burst_mode,
        input  channel_transfer_enable, request_pending, bus_grant, operand_running, irq_request
    );
endinterface

//--- shared/dce_pkg.sv
package dce_pkg;
    localparam int          NCH             = 2;
    localparam int          DEV_AW          = 24;
    // Device register map (byte addresses on the device's own register port).
    localparam logic [23:0] DEV_ENABLE_OFS  = 24'hEF8000;
    localparam logic [23:0] DEV_IRQ_STS_OFS = 24'hEF8004;
    localparam logic [23:0] DEV_END_DET_OFS = 24'hEF800C;
    // Field positions, lowest channel first.
    localparam int          MASK_POS        = 16;
    localparam int          EN_POS          = 24;
    localparam int          IRQ_POS         = 16;
    localparam int          EDET_POS        = 16;
    localparam logic [31:0] REG_RST         = 32'h0000_0000;
    localparam logic        BIT_RST         = 1'b0;
    // Controller register map on APB (byte addresses).
    localparam int          CAW             = 12;
    localparam logic [11:0] CTL_CTRL_OFS    = 12'h000;
    localparam logic [11:0] CTL_EVENT_OFS   = 12'h004;
    localparam logic [11:0] CTL_ADDR_OFS    = 12'h008;
    localparam logic [11:0] CTL_WDATA_OFS   = 12'h00C;
    localparam logic [11:0] CTL_CMD_OFS     = 12'h010;
    localparam logic [11:0] CTL_RDATA_OFS   = 12'h014;
    localparam logic [11:0] CTL_STATUS_OFS  = 12'h018;
    // Controller field positions.
    localparam int          CF_IRQEN_POS    = 0;
    localparam int          CF_AUTODIS_POS  = 2;
    localparam int          CF_BURST_POS    = 4;
    localparam int          EV_REQ_POS      = 0;
    localparam int          EV_END_POS      = 2;
    localparam int          EV_DONE_POS     = 4;
    localparam int          EV_ABORT_POS    = 6;
    localparam int          CMD_BE_POS      = 0;
    localparam int          CMD_WRITE_POS   = 4;
    localparam int          ST_EN_POS       = 0;
    localparam int          ST_PEND_POS     = 2;
    localparam int          ST_GRANT_POS    = 4;
    localparam int          ST_RUN_POS      = 6;
    localparam int          ST_BUSY_POS     = 7;
    localparam int          ST_IRQ_POS      = 8;

    typedef enum logic [1:0] {DCE_IDLE, DCE_RUN, DCE_HALT} dce_xfer_state_t;
endpackage

//--- sim/dce_assertions.sv
`timescale 1ns/1ps
module dce_assertions (
    input wire logic                       pclk,
    input wire logic                       presetn,
    input wire logic                       dev_req,
    input wire logic                       dev_write,
    input wire logic [dce_pkg::DEV_AW-1:0] dev_addr,
    input wire logic [3:0]                 dev_be,
    input wire logic [31:0]                dev_wdata,
    input wire logic [31:0]                dev_rdata,
    input wire logic                       dev_ack,
    input wire logic [dce_pkg::NCH-1:0]    dma_request,
    input wire logic [dce_pkg::NCH-1:0]    end_event,
    input wire logic [dce_pkg::NCH-1:0]    operand_done,
    input wire logic [dce_pkg::NCH-1:0]    transfer_state_abort,
    input wire logic [dce_pkg::NCH-1:0]    end_irq_enable,
    input wire logic [dce_pkg::NCH-1:0]    auto_disable_on_end,
    input wire logic                       burst_mode,
    input wire logic [dce_pkg::NCH-1:0]    channel_transfer_enable,
    input wire logic [dce_pkg::NCH-1:0]    request_pending,
    input wire logic [dce_pkg::NCH-1:0]    bus_grant,
    input wire logic                       operand_running,
    input wire logic [dce_pkg::NCH-1:0]    irq_request
);
    import dce_pkg::*;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_en_wr;
        dev_req && !dev_ack && dev_write && dev_addr == DEV_ENABLE_OFS && dev_be[3:2] == 2'b11 && end_event == '0;
    endsequence

    property p_ack_next;
        dev_req && !dev_ack |=> dev_ack ##1 !dev_ack;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("device access answer not one cycle");
    property p_mask_keep;
        s_en_wr ##0 dev_wdata[17:16] == 2'b00 |=> $stable(channel_transfer_enable);
    endproperty
    a_mask_keep: assert property (p_mask_keep) else $error("masked enable write changed enable");
    property p_mask_load;
        s_en_wr ##0 dev_wdata[17:16] == 2'b11 |=> channel_transfer_enable == $past(dev_wdata[25:24]);
    endproperty
    a_mask_load: assert property (p_mask_load) else $error("unmasked enable write not loaded");
    property p_rd_zero;
        dev_ack && !$past(dev_write) && $past(dev_addr) == DEV_ENABLE_OFS |-> dev_rdata[23:0] == '0 && dev_rdata[31:26] == '0;
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("enable read shows mask or spare bits");
    property p_pend;
        dma_request[1] && !channel_transfer_enable[1] |=> request_pending[1];
    endproperty
    a_pend: assert property (p_pend) else $error("request lost while channel disabled");
    property p_grant_en;
        $changed(bus_grant) && bus_grant != '0 |-> (bus_grant & $past(channel_transfer_enable)) != '0;
    endproperty
    a_grant_en: assert property (p_grant_en) else $error("bus granted to disabled channel");
    property p_no_switch;
        bus_grant != '0 && (bus_grant & (operand_done | transfer_state_abort)) == '0 |=> bus_grant == $past(bus_grant);
    endproperty
    a_no_switch: assert property (p_no_switch) else $error("bus owner changed mid operand");
    property p_halt;
        operand_running && !burst_mode && channel_transfer_enable == '0 |=> !operand_running;
    endproperty
    a_halt: assert property (p_halt) else $error("operand not paused with all enables off");
    property p_irq_set;
        end_event[0] && end_irq_enable[0] |=> irq_request[0];
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("end with irq enable did not raise irq");
    property p_irq_clr;
        !end_irq_enable[1] |=> !irq_request[1];
    endproperty
    a_irq_clr: assert property (p_irq_clr) else $error("irq kept with irq enable off");
    property p_auto;
        end_event[0] && auto_disable_on_end[0] |=> !channel_transfer_enable[0];
    endproperty
    a_auto: assert property (p_auto) else $error("auto disable did not clear enable");
    property p_sts_ro;
        dev_req && !dev_ack && dev_write && dev_addr == DEV_IRQ_STS_OFS && end_event == '0 |=> $stable(irq_request);
    endproperty
    a_sts_ro: assert property (p_sts_ro) else $error("status register write took effect");

    c_halt: cover property (operand_running ##1 !operand_running && bus_grant != '0);
    c_irq: cover property ($rose(irq_request[0]));
    c_abort: cover property (transfer_state_abort != '0 && bus_grant != '0);
endmodule // dce_assertions

//--- sim/dce_tb_top.sv
`timescale 1ns/1ps
module dce_tb_top;
    import dce_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic [31:0] rd;
    int          num_errors;
    int          total_checks;
    int          cycles = 0;

    dce_link_if link ();
    dce_ctrl i_dce_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
                         .pslverr(), .link(link.ctrl));
    dce_device i_dce_device (.pclk, .presetn, .link(link.device));
    dce_assertions i_dce_assertions (.pclk, .presetn, .dev_req(link.dev_req), .dev_write(link.dev_write),
        .dev_addr(link.dev_addr), .dev_be(link.dev_be), .dev_wdata(link.dev_wdata), .dev_rdata(link.dev_rdata),
        .dev_ack(link.dev_ack), .dma_request(link.dma_request), .end_event(link.end_event),
        .operand_done(link.operand_done), .transfer_state_abort(link.transfer_state_abort),
        .end_irq_enable(link.end_irq_enable), .auto_disable_on_end(link.auto_disable_on_end),
        .burst_mode(link.burst_mode), .channel_transfer_enable(link.channel_transfer_enable),
        .request_pending(link.request_pending), .bus_grant(link.bus_grant),
        .operand_running(link.operand_running), .irq_request(link.irq_request));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic wrap_up;
        if (num_errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // A hung handshake never returns, so the cycle ceiling is the only way out.
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            wrap_up();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Design outputs change by non-blocking update, so values read right after the edge are the sampled ones.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic dev(input logic wr, input logic [23:0] a, input logic [3:0] be, input logic [31:0] d);
        logic [31:0] q;
        int          n = 0;
        apb(1'b1, CTL_ADDR_OFS, {8'h00, a}, q);
        apb(1'b1, CTL_WDATA_OFS, d, q);
        apb(1'b1, CTL_CMD_OFS, {27'h0, wr, be}, q);
        do begin
            apb(1'b0, CTL_STATUS_OFS, 32'h0, q);
            n++;
        end while (q[ST_BUSY_POS] !== 1'b0 && n < 50);
        chk("busy", {31'h0, q[ST_BUSY_POS]}, 32'h0);
        apb(1'b0, CTL_RDATA_OFS, 32'h0, rd);
    endtask

    task automatic dchk(input string what, input logic [23:0] a, input logic [31:0] exp);
        dev(1'b0, a, 4'hF, 32'h0);
        chk(what, rd, exp);
    endtask

    task automatic schk(input logic [31:0] exp);
        apb(1'b0, CTL_STATUS_OFS, 32'h0, rd);
        chk("status", rd, exp);
    endtask

    task automatic cwr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd);
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        num_errors = 0;
        total_checks = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        schk(32'h0);
        dchk("enable", DEV_ENABLE_OFS, 32'h0);
        dchk("irq_sts", DEV_IRQ_STS_OFS, 32'h0);
        dev(1'b1, DEV_ENABLE_OFS, 4'hF, 32'h0301_0000);
        dchk("enable", DEV_ENABLE_OFS, 32'h0100_0000);
        dev(1'b1, DEV_ENABLE_OFS, 4'hF, 32'h0300_0000);
        dchk("enable", DEV_ENABLE_OFS, 32'h0100_0000);
        dev(1'b1, DEV_ENABLE_OFS, 4'hF, 32'h0202_0000);
        dchk("enable", DEV_ENABLE_OFS, 32'h0300_0000);
        dev(1'b1, DEV_ENABLE_OFS, 4'b1100, 32'h0003_0000);
        dchk("enable", DEV_ENABLE_OFS, 32'h0);
        dev(1'b1, DEV_IRQ_STS_OFS, 4'hF, 32'h0003_0000);
        dchk("irq_sts", DEV_IRQ_STS_OFS, 32'h0);
        // Channel 1 requests while disabled, then gets the bus once enabled.
        cwr(CTL_EVENT_OFS, 32'h02);
        schk(32'h08);
        dev(1'b1, DEV_ENABLE_OFS, 4'b1100, 32'h0202_0000);
        schk(32'h62);
        cwr(CTL_EVENT_OFS, 32'h01);
        schk(32'h66);
        dev(1'b1, DEV_ENABLE_OFS, 4'b1100, 32'h0003_0000);
        schk(32'h24);
        dev(1'b1, DEV_ENABLE_OFS, 4'b1100, 32'h0202_0000);
        schk(32'h66);
        dev(1'b1, DEV_ENABLE_OFS, 4'b1100, 32'h0003_0000);
        cwr(CTL_EVENT_OFS, 32'h80);
        schk(32'h04);
        dev(1'b1, DEV_ENABLE_OFS, 4'b1100, 32'h0101_0000);
        schk(32'h51);
        cwr(CTL_EVENT_OFS, 32'h10);
        schk(32'h01);
        // End on channel 0 with interrupt and auto-disable both on.
        cwr(CTL_CTRL_OFS, 32'h05);
        cwr(CTL_EVENT_OFS, 32'h04);
        schk(32'h100);
        dchk("end_det", DEV_END_DET_OFS, 32'h0001_0000);
        dchk("irq_sts", DEV_IRQ_STS_OFS, 32'h0001_0000);
        dev(1'b1, DEV_END_DET_OFS, 4'b0100, 32'h0003_0000);
        dchk("end_det", DEV_END_DET_OFS, 32'h0001_0000);
        dev(1'b1, DEV_END_DET_OFS, 4'b0100, 32'h0);
        dchk("irq_sts", DEV_IRQ_STS_OFS, 32'h0);
        cwr(CTL_CTRL_OFS, 32'h02);
        cwr(CTL_EVENT_OFS, 32'h08);
        schk(32'h200);
        cwr(CTL_CTRL_OFS, 32'h00);
        schk(32'h0);
        dchk("end_det", DEV_END_DET_OFS, 32'h0002_0000);
        // Burst mode: clearing every enable leaves the running operand alone.
        cwr(CTL_CTRL_OFS, 32'h10);
        cwr(CTL_EVENT_OFS, 32'h01);
        dev(1'b1, DEV_ENABLE_OFS, 4'b1100, 32'h0101_0000);
        dev(1'b1, DEV_ENABLE_OFS, 4'b1100, 32'h0003_0000);
        schk(32'h50);
        wrap_up();
    end
endmodule // dce_tb_top
